// ### rtl/tlx_map.svh
// Offsets, field positions and reset values for the table transfer block
`ifndef TLX_MAP_SVH
`define TLX_MAP_SVH
`define TLX_ADDR_CTRL     12'h000
`define TLX_ADDR_STATUS   12'h004
`define TLX_ADDR_WORKING_REGISTER     12'h008
`define TLX_ADDR_PTR      12'h00C
`define TLX_ADDR_LATCH    12'h010
`define TLX_ADDR_FLAGS    12'h014
`define TLX_ADDR_FILE     12'h018
`define TLX_ADDR_IBOUND   12'h01C
`define TLX_CTRL_GO_BIT   0
`define TLX_CTRL_OP_LSB   1
`define TLX_CTRL_T_BIT    3
`define TLX_CTRL_I_BIT    4
`define TLX_CTRL_ARG_LSB  8
`define TLX_CTRL_WAKE_BIT 16
`define TLX_CTRL_WDT_BIT  17
`define TLX_CTRL_SLP_BIT  18
`define TLX_FLG_C         0
`define TLX_FLG_DC        1
`define TLX_FLG_Z         2
`define TLX_FLG_OV        3
`define TLX_FLG_TO        4
`define TLX_FLG_PD        5
`define TLX_IBOUND_RST    16'h0800
`define TLX_FLG_RST       6'h30
`define TLX_FILE_WORDS    256
`endif

// ### rtl/tlx_pkg.sv
// Types shared by the table transfer block
package tlx_pkg;
  typedef enum logic [1:0] {
    TLX_OP_SUBLIT,
    TLX_OP_TWRITE,
    TLX_OP_LREAD,
    TLX_OP_SLEEP
  } tlx_op_t;

  typedef struct packed {
    logic       ov;
    logic       z;
    logic       dc;
    logic       c;
    logic [7:0] res;
  } tlx_alu_t;

  typedef struct packed {
    logic        req;
    logic [15:0] addr;
    logic [15:0] data;
  } tlx_pm_t;
endpackage : tlx_pkg

// ### rtl/tlx_sublit.sv
// Literal minus working register arithmetic
`timescale 1ns/1ns
`default_nettype none
module tlx_sublit (
  input  wire logic [7:0]       lit,
  input  wire logic [7:0]       working_register,
  output tlx_pkg::tlx_alu_t     alu
);
  logic [8:0] full;
  logic [4:0] half;
  always_comb begin
    full    = {1'b0, lit} + {1'b0, ~working_register} + 9'h001;
    half    = {1'b0, lit[3:0]} + {1'b0, ~working_register[3:0]} + 5'h01;
    alu.res = full[7:0];
    alu.c   = full[8];
    alu.dc  = half[4];
    alu.z   = (full[7:0] == 8'h00);
    alu.ov  = (lit[7] != working_register[7]) && (full[7] != lit[7]);
  end
endmodule : tlx_sublit
`default_nettype wire

// ### rtl/tlx_filemem.sv
// Byte-wide file register array with one write and one read port
`timescale 1ns/1ns
`default_nettype none
module tlx_filemem #(
  parameter int WORDS = 256
) (
  input  wire logic       clk,
  input  wire logic       we,
  input  wire logic [7:0] waddr,
  input  wire logic [7:0] wdata,
  input  wire logic [7:0] raddr,
  output logic      [7:0] rdata
);
  logic [7:0] mem [WORDS];
  // Eight-bit addresses reach exactly 256 words
  if (WORDS != 256) begin : g_words_chk
    $error("tlx_filemem needs 256 words");
  end
  always_ff @(posedge clk) begin
    if (we) mem[waddr] <= wdata;
  end
  always_comb rdata = mem[raddr];
endmodule : tlx_filemem
`default_nettype wire

// ### rtl/tlx_core.sv
// Table write, latch read, subtract-from-literal and sleep flag logic
// Function
// - Watchdog wake from sleep clears the timeout flag
// - Subtract-literal computes literal minus working register, updates OV C DC Z
// - Subtract-literal result replaces working register
// - Table write takes file address 0..255, byte select and increment bits
// - Table write first copies file byte into the table latch
// - Byte select 0 loads latch low, 1 loads latch high
// - Then whole latch is written to program memory at pointer
// - Table write to external memory completes in two cycles
// - Table write to on-chip memory runs long, ends on array ack or interrupt
// - Table write is two cycles nominally, many for on-chip memory
// - After table write pointer increments when increment bit is one
// - Latch read copies one latch byte into file register
// - Latch read leaves latch, program memory and pointer untouched
// - Latch read fetches byte, executes, writes file register last
`timescale 1ns/1ns
`default_nettype none
`include "tlx_map.svh"
module tlx_core (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        irq,
  input  wire logic        pm_ack,
  output logic             pm_req,
  output logic      [15:0] pm_addr,
  output logic      [15:0] pm_data,
  output logic             pm_internal
);
  typedef enum logic [2:0] {ST_IDLE, ST_FETCH, ST_EXEC, ST_EXT, ST_INT} tlx_st_t;

  tlx_st_t             st_reg, st_next;
  tlx_pkg::tlx_op_t    op_reg, op_next;
  logic                t_reg, t_next, i_reg, i_next;
  logic [7:0]          arg_reg, arg_next;
  logic [7:0]          working_register_reg, working_register_next;
  logic [15:0]         ptr_reg, ptr_next;
  logic [15:0]         lat_reg, lat_next;
  logic [5:0]          flg_reg, flg_next;
  logic [15:0]         ibound_reg, ibound_next;
  logic                busy_reg, busy_next;
  logic [7:0]          rbyte_reg, rbyte_next;
  logic [31:0]         prdata_reg, prdata_next;
  logic                pready_reg, pready_next;
  logic                pslverr_reg, pslverr_next;
  tlx_pkg::tlx_pm_t    pm_reg, pm_next;
  logic                pmi_reg, pmi_next;
  logic                fwe;
  logic [7:0]          fwaddr, fwdata, fraddr, frdata;
  tlx_pkg::tlx_alu_t   alu;
  logic                acc, wr_ok;

  tlx_sublit u_alu (
    .lit  (arg_reg),
    .working_register (working_register_reg),
    .alu  (alu)
  );

  tlx_filemem #(.WORDS(`TLX_FILE_WORDS)) u_file (
    .clk   (clk),
    .we    (fwe),
    .waddr (fwaddr),
    .wdata (fwdata),
    .raddr (fraddr),
    .rdata (frdata)
  );

  function automatic logic [15:0] inc16(input logic [15:0] v);
    inc16 = v + 16'h0001;
  endfunction : inc16

  assign acc         = psel && penable && !pready_reg;
  assign prdata      = prdata_reg;
  assign pready      = pready_reg;
  assign pslverr     = pslverr_reg;
  assign pm_req      = pm_reg.req;
  assign pm_addr     = pm_reg.addr;
  assign pm_data     = pm_reg.data;
  assign pm_internal = pmi_reg;

  always_comb begin
    st_next      = st_reg;
    op_next      = op_reg;
    t_next       = t_reg;
    i_next       = i_reg;
    arg_next     = arg_reg;
    working_register_next    = working_register_reg;
    ptr_next     = ptr_reg;
    lat_next     = lat_reg;
    flg_next     = flg_reg;
    ibound_next  = ibound_reg;
    busy_next    = busy_reg;
    rbyte_next   = rbyte_reg;
    prdata_next  = prdata_reg;
    pready_next  = 1'b0;
    pslverr_next = 1'b0;
    pm_next      = pm_reg;
    pmi_next     = pmi_reg;
    fwe          = 1'b0;
    fwaddr       = arg_reg;
    fwdata       = rbyte_reg;
    fraddr       = arg_reg;
    wr_ok        = 1'b0;
    // Bus slave, one wait state; pointer and latch locked while busy
    if (acc) begin
      pready_next = 1'b1;
      if (pwrite) begin
        unique case (paddr)
          `TLX_ADDR_CTRL: begin
            if (pwdata[`TLX_CTRL_GO_BIT] && !busy_reg) begin
              op_next   = tlx_pkg::tlx_op_t'(pwdata[`TLX_CTRL_OP_LSB +: 2]);
              t_next    = pwdata[`TLX_CTRL_T_BIT];
              i_next    = pwdata[`TLX_CTRL_I_BIT];
              arg_next  = pwdata[`TLX_CTRL_ARG_LSB +: 8];
              busy_next = 1'b1;
              st_next   = ST_FETCH;
            end else if (pwdata[`TLX_CTRL_GO_BIT]) begin
              pslverr_next = 1'b1;
            end
            // Powerdown flag is low while asleep, so only then is a wake honoured
            if (pwdata[`TLX_CTRL_WAKE_BIT] && !flg_reg[`TLX_FLG_PD]) begin
              flg_next[`TLX_FLG_PD] = 1'b1;
              // Watchdog wake clears timeout, other wakes leave it set
              if (pwdata[`TLX_CTRL_WDT_BIT]) flg_next[`TLX_FLG_TO] = 1'b0;
            end
          end
          `TLX_ADDR_WORKING_REGISTER:   if (!busy_reg) working_register_next = pwdata[7:0];
          `TLX_ADDR_PTR:    if (!busy_reg) ptr_next = pwdata[15:0];
          `TLX_ADDR_LATCH:  if (!busy_reg) lat_next = pwdata[15:0];
          `TLX_ADDR_IBOUND: ibound_next = pwdata[15:0];
          `TLX_ADDR_FILE: begin
            if (!busy_reg) begin
              wr_ok  = 1'b1;
              fwe    = 1'b1;
              fwaddr = pwdata[15:8];
              fwdata = pwdata[7:0];
            end else begin
              pslverr_next = 1'b1;
            end
          end
          `TLX_ADDR_STATUS, `TLX_ADDR_FLAGS: ;
          default: pslverr_next = 1'b1;
        endcase
      end else begin
        unique case (paddr)
          `TLX_ADDR_CTRL:   prdata_next = {29'h0000_0000, i_reg, t_reg, 1'b0};
          `TLX_ADDR_STATUS: prdata_next = {28'h0000_0000, 1'b0, st_reg};
          `TLX_ADDR_WORKING_REGISTER:   prdata_next = {24'h00_0000, working_register_reg};
          `TLX_ADDR_PTR:    prdata_next = {16'h0000, ptr_reg};
          `TLX_ADDR_LATCH:  prdata_next = {16'h0000, lat_reg};
          `TLX_ADDR_FLAGS:  prdata_next = {26'h000_0000, flg_reg};
          `TLX_ADDR_IBOUND: prdata_next = {16'h0000, ibound_reg};
          `TLX_ADDR_FILE: begin
            fraddr      = pwdata[15:8];
            prdata_next = {24'h00_0000, frdata};
          end
          default: begin
            prdata_next  = 32'h0000_0000;
            pslverr_next = 1'b1;
          end
        endcase
      end
    end
    // Execution; file writes from the bus are refused while busy
    unique case (st_reg)
      ST_IDLE: ;
      ST_FETCH: begin
        fraddr = arg_reg;
        unique case (op_reg)
          tlx_pkg::TLX_OP_SUBLIT: begin
            working_register_next = alu.res;
            flg_next[`TLX_FLG_C]  = alu.c;
            flg_next[`TLX_FLG_DC] = alu.dc;
            flg_next[`TLX_FLG_Z]  = alu.z;
            flg_next[`TLX_FLG_OV] = alu.ov;
            st_next   = ST_IDLE;
            busy_next = 1'b0;
          end
          tlx_pkg::TLX_OP_TWRITE: begin
            // Latch byte chosen by select, other byte kept
            if (t_reg) lat_next[15:8] = frdata;
            else       lat_next[7:0]  = frdata;
            st_next = ST_EXEC;
          end
          tlx_pkg::TLX_OP_LREAD: begin
            rbyte_next = t_reg ? lat_reg[15:8] : lat_reg[7:0];
            st_next    = ST_EXEC;
          end
          tlx_pkg::TLX_OP_SLEEP: begin
            flg_next[`TLX_FLG_TO] = 1'b1;
            flg_next[`TLX_FLG_PD] = 1'b0;
            st_next   = ST_IDLE;
            busy_next = 1'b0;
          end
        endcase
      end
      ST_EXEC: begin
        if (op_reg == tlx_pkg::TLX_OP_LREAD) begin
          // Write-back last; latch and pointer left alone
          fwe       = !wr_ok;
          fwaddr    = arg_reg;
          fwdata    = rbyte_reg;
          st_next   = wr_ok ? ST_EXEC : ST_IDLE;
          busy_next = wr_ok;
        end else begin
          pm_next.req  = 1'b1;
          pm_next.addr = ptr_reg;
          pm_next.data = lat_reg;
          pmi_next     = ptr_reg < ibound_reg;
          st_next      = (ptr_reg < ibound_reg) ? ST_INT : ST_EXT;
        end
      end
      ST_EXT: begin
        pm_next.req = 1'b0;
        if (i_reg) ptr_next = inc16(ptr_reg);
        st_next   = ST_IDLE;
        busy_next = 1'b0;
      end
      ST_INT: begin
        // On-chip programming holds until the array acks or an interrupt ends it
        if (irq || pm_ack) begin
          pm_next.req = 1'b0;
          pmi_next    = 1'b0;
          if (i_reg) ptr_next = inc16(ptr_reg);
          st_next   = ST_IDLE;
          busy_next = 1'b0;
        end
      end
      default: st_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg      <= ST_IDLE;
      op_reg      <= tlx_pkg::TLX_OP_SUBLIT;
      t_reg       <= 1'b0;
      i_reg       <= 1'b0;
      arg_reg     <= 8'h00;
      working_register_reg    <= 8'h00;
      ptr_reg     <= 16'h0000;
      lat_reg     <= 16'h0000;
      flg_reg     <= `TLX_FLG_RST;
      ibound_reg  <= `TLX_IBOUND_RST;
      busy_reg    <= 1'b0;
      rbyte_reg   <= 8'h00;
      prdata_reg  <= 32'h0000_0000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      pm_reg      <= '0;
      pmi_reg     <= 1'b0;
    end else begin
      st_reg      <= st_next;
      op_reg      <= op_next;
      t_reg       <= t_next;
      i_reg       <= i_next;
      arg_reg     <= arg_next;
      working_register_reg    <= working_register_next;
      ptr_reg     <= ptr_next;
      lat_reg     <= lat_next;
      flg_reg     <= flg_next;
      ibound_reg  <= ibound_next;
      busy_reg    <= busy_next;
      rbyte_reg   <= rbyte_next;
      prdata_reg  <= prdata_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
      pm_reg      <= pm_next;
      pmi_reg     <= pmi_next;
    end
  end

  ext_two_cyc_a: assert property (@(posedge clk) disable iff (!rst_n)
    (st_reg == ST_EXEC && op_reg == tlx_pkg::TLX_OP_TWRITE && ptr_reg >= ibound_reg)
    |=> pm_reg.req ##1 !pm_reg.req && st_reg == ST_IDLE)
    else $error("external table write not two cycles");
  ptr_inc_a: assert property (@(posedge clk) disable iff (!rst_n)
    (st_reg == ST_EXT && i_reg) |=> ptr_reg == $past(ptr_reg) + 16'h0001)
    else $error("pointer not incremented");
  ptr_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (st_reg == ST_EXEC && op_reg == tlx_pkg::TLX_OP_LREAD) |=> $stable(ptr_reg)
      && $stable(lat_reg))
    else $error("latch read disturbed latch or pointer");
  int_stop_a: assert property (@(posedge clk) disable iff (!rst_n)
    (st_reg == ST_INT && irq) |=> !pm_reg.req && st_reg == ST_IDLE)
    else $error("interrupt did not end on-chip write");
  lat_byte_a: assert property (@(posedge clk) disable iff (!rst_n)
    (st_reg == ST_FETCH && op_reg == tlx_pkg::TLX_OP_TWRITE && t_reg)
    |=> lat_reg[7:0] == $past(lat_reg[7:0]) && lat_reg[15:8] == $past(frdata))
    else $error("wrong latch byte loaded");
  pm_data_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(pm_reg.req) |-> pm_reg.data == lat_reg && pm_reg.addr == ptr_reg)
    else $error("program word not latch at pointer");
  sub_working_register_a: assert property (@(posedge clk) disable iff (!rst_n)
    (st_reg == ST_FETCH && op_reg == tlx_pkg::TLX_OP_SUBLIT)
    |=> working_register_reg == $past(arg_reg) - $past(working_register_reg))
    else $error("subtract result wrong");
  sub_carry_a: assert property (@(posedge clk) disable iff (!rst_n)
    (st_reg == ST_FETCH && op_reg == tlx_pkg::TLX_OP_SUBLIT)
    |=> flg_reg[`TLX_FLG_C] == ($past(arg_reg) >= $past(working_register_reg)))
    else $error("carry not inverted borrow");
endmodule : tlx_core
`default_nettype wire

// ### tb/tlx_pm_model.sv
// Program memory model facing the table write port
`timescale 1ns/1ns
`default_nettype none
module tlx_pm_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        pm_req,
  input  wire logic [15:0] pm_addr,
  input  wire logic [15:0] pm_data,
  input  wire logic        pm_internal,
  input  wire logic [7:0]  ack_delay,
  output logic             pm_ack,
  output logic      [15:0] last_addr,
  output logic      [15:0] last_data,
  output logic             last_int,
  output logic      [7:0]  req_len,
  output logic      [7:0]  n_writes
);
  logic [7:0] cnt;
  // Zero delay never acknowledges, so only an interrupt can end the write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt       <= 8'h00;
      pm_ack    <= 1'b0;
      n_writes  <= 8'h00;
      last_addr <= 16'h0000;
      last_data <= 16'h0000;
      last_int  <= 1'b0;
      req_len   <= 8'h00;
    end else if (pm_req) begin
      cnt       <= cnt + 8'h01;
      last_addr <= pm_addr;
      last_data <= pm_data;
      last_int  <= pm_internal;
      pm_ack    <= pm_internal && ack_delay != 8'h00 && cnt + 8'h01 >= ack_delay;
    end else begin
      pm_ack <= 1'b0;
      if (cnt != 8'h00) begin
        req_len  <= cnt;
        n_writes <= n_writes + 8'h01;
      end
      cnt <= 8'h00;
    end
  end
endmodule : tlx_pm_model
`default_nettype wire

// ### tb/table_latch_transfer_ops_tb.sv
// Self-checking bench for the table transfer block
`timescale 1ns/1ns
`default_nettype none
`include "tlx_map.svh"
module table_latch_transfer_ops_tb;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, irq, rerr;
  logic        pm_ack, pm_req, pm_internal, last_int;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [15:0] pm_addr, pm_data, last_addr, last_data;
  logic [7:0]  ack_delay, req_len, n_writes;
  int          mismatches, n_tests;

  tlx_core dut_u (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .pm_ack(pm_ack), .pm_req(pm_req), .pm_addr(pm_addr),
    .pm_data(pm_data), .pm_internal(pm_internal));
  tlx_pm_model pm_u (.clk(clk), .rst_n(rst_n), .pm_req(pm_req), .pm_addr(pm_addr),
    .pm_data(pm_data), .pm_internal(pm_internal), .ack_delay(ack_delay), .pm_ack(pm_ack),
    .last_addr(last_addr), .last_data(last_data), .last_int(last_int),
    .req_len(req_len), .n_writes(n_writes));

  always #2 clk = ~clk;

  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    penable <= 1'b0;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      mismatches++;
      report_and_stop;
    end
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wait_idle;
    int k;
    k = 0;
    do begin
      apb(1'b0, `TLX_ADDR_STATUS, 32'h0000_0000);
      k++;
    end while (rdat[2:0] !== 3'h0 && k < 200);
    if (k >= 200) begin
      mismatches++;
      report_and_stop;
    end
  endtask : wait_idle

  task run(input tlx_pkg::tlx_op_t op, input logic t, input logic i, input logic [7:0] arg);
    apb(1'b1, `TLX_ADDR_CTRL, {16'h0000, arg, 3'h0, i, t, op, 1'b1});
    wait_idle();
  endtask : run

  task t_sub(input logic [7:0] k, input logic [7:0] w);
    logic [7:0] r;
    r = k - w;
    apb(1'b1, `TLX_ADDR_WORKING_REGISTER, {24'h00_0000, w});
    run(tlx_pkg::TLX_OP_SUBLIT, 1'b0, 1'b0, k);
    apb(1'b0, `TLX_ADDR_WORKING_REGISTER, 32'h0000_0000);
    check(rdat[7:0], r);
    apb(1'b0, `TLX_ADDR_FLAGS, 32'h0000_0000);
    check(rdat[3:0], {(k[7] != w[7]) && (r[7] != k[7]), r == 8'h00, k[3:0] >= w[3:0], k >= w});
  endtask : t_sub

  task t_tw_ext(input logic [15:0] ptr, input logic [15:0] lat, input logic [7:0] b,
                input logic t, input logic i);
    logic [15:0] exp;
    logic [7:0]  n;
    exp = t ? {b, lat[7:0]} : {lat[15:8], b};
    apb(1'b1, `TLX_ADDR_FILE, {16'h0000, 8'hFF, b});
    apb(1'b1, `TLX_ADDR_PTR, {16'h0000, ptr});
    apb(1'b1, `TLX_ADDR_LATCH, {16'h0000, lat});
    n = n_writes;
    run(tlx_pkg::TLX_OP_TWRITE, t, i, 8'hFF);
    check(last_addr, ptr);
    check(last_data, exp);
    check(n_writes, n + 8'h01);
    check({last_int, req_len}, 9'h001);
    apb(1'b0, `TLX_ADDR_PTR, 32'h0000_0000);
    check(rdat[15:0], 16'(ptr + {15'h0000, i}));
    apb(1'b0, `TLX_ADDR_LATCH, 32'h0000_0000);
    check(rdat[15:0], exp);
  endtask : t_tw_ext

  task t_tw_int(input logic use_irq);
    ack_delay <= use_irq ? 8'h00 : 8'h06;
    apb(1'b1, `TLX_ADDR_FILE, 32'h0000_403C);
    apb(1'b1, `TLX_ADDR_PTR, 32'h0000_0010);
    if (use_irq) begin
      apb(1'b1, `TLX_ADDR_CTRL, 32'h0000_4003);
      apb(1'b1, `TLX_ADDR_CTRL, 32'h0000_4003);
      check(rerr, 1'b1);
      repeat (10) @(posedge clk);
      irq <= 1'b1;
      wait_idle();
      irq <= 1'b0;
    end else
      run(tlx_pkg::TLX_OP_TWRITE, 1'b0, 1'b0, 8'h40);
    check(last_int, 1'b1);
    check(last_addr, 16'h0010);
    check(last_data, 16'h123C);
    check(req_len > 8'h02, 1'b1);
  endtask : t_tw_int

  task t_lrd;
    logic [7:0] n;
    apb(1'b1, `TLX_ADDR_LATCH, 32'h0000_00AF);
    apb(1'b1, `TLX_ADDR_PTR, 32'h0000_1234);
    n = n_writes;
    run(tlx_pkg::TLX_OP_LREAD, 1'b0, 1'b0, 8'h21);
    run(tlx_pkg::TLX_OP_LREAD, 1'b1, 1'b0, 8'hFF);
    apb(1'b0, `TLX_ADDR_FILE, 32'h0000_2100);
    check(rdat[7:0], 8'hAF);
    apb(1'b0, `TLX_ADDR_FILE, 32'h0000_FF00);
    check(rdat[7:0], 8'h00);
    apb(1'b0, `TLX_ADDR_LATCH, 32'h0000_0000);
    check(rdat[15:0], 16'h00AF);
    apb(1'b0, `TLX_ADDR_PTR, 32'h0000_0000);
    check(rdat[15:0], 16'h1234);
    check(n_writes, n);
  endtask : t_lrd

  task t_sleep(input logic [31:0] wake, input logic [1:0] exp);
    run(tlx_pkg::TLX_OP_SLEEP, 1'b0, 1'b0, 8'h00);
    apb(1'b0, `TLX_ADDR_FLAGS, 32'h0000_0000);
    check(rdat[5:4], 2'b01);
    apb(1'b1, `TLX_ADDR_CTRL, wake);
    apb(1'b0, `TLX_ADDR_FLAGS, 32'h0000_0000);
    check(rdat[5:4], exp);
  endtask : t_sleep

  initial begin
    clk        = 1'b0;
    rst_n      = 1'b0;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    paddr      = 12'h000;
    pwdata     = 32'h0000_0000;
    irq        = 1'b0;
    ack_delay  = 8'h00;
    mismatches = 0;
    n_tests    = 0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, `TLX_ADDR_FLAGS, 32'h0000_0000);
    check(rdat[5:0], 6'h30);
    apb(1'b0, `TLX_ADDR_IBOUND, 32'h0000_0000);
    check(rdat, {16'h0000, `TLX_IBOUND_RST});
    apb(1'b0, 12'h020, 32'h0000_0000);
    check(rerr, 1'b1);
    check(rdat, 32'h0000_0000);
    t_sub(8'h02, 8'h01);
    t_sub(8'h02, 8'h02);
    t_sub(8'h02, 8'h03);
    t_sub(8'h7F, 8'h80);
    t_sub(8'h80, 8'h01);
    t_tw_ext(16'hA356, 16'hAA55, 8'h53, 1'b0, 1'b1);
    t_tw_ext(16'hA356, 16'hAA55, 8'h53, 1'b1, 1'b0);
    t_tw_ext(16'hFFFF, 16'h1234, 8'h9C, 1'b0, 1'b1);
    t_tw_int(1'b0);
    t_tw_int(1'b1);
    t_lrd();
    t_sleep(32'h0001_0000, 2'b11);
    t_sleep(32'h0003_0000, 2'b10);
    report_and_stop();
  end
endmodule : table_latch_transfer_ops_tb
`default_nettype wire
